// *** src/crcms_pkg.sv ***
package crcms_pkg;

  // APB byte addresses of the word-wide registers
  localparam logic [7:0] ADDR_CTRL    = 8'h00; // crc_control_primary
  localparam logic [7:0] ADDR_LEN     = 8'h04; // crc_length_config
  localparam logic [7:0] ADDR_DATH    = 8'h08; // crc_input_high_byte
  localparam logic [7:0] ADDR_DATL    = 8'h0C; // crc_input_low_byte
  localparam logic [7:0] ADDR_ACC     = 8'h10; // checksum_accumulator, 16 bits
  localparam logic [7:0] ADDR_XOR     = 8'h14; // polynomial_tap_register, 16 bits
  localparam logic [7:0] ADDR_SHIFT   = 8'h18; // shifter, read only
  localparam logic [7:0] ADDR_SCTRL   = 8'h1C; // scanner_control
  localparam logic [7:0] ADDR_SLOW    = 8'h20; // scan_low_address
  localparam logic [7:0] ADDR_SHIGH   = 8'h24; // scan_high_address
  localparam logic [7:0] ADDR_FLAGS   = 8'h28; // done flags, write 1 to clear

  // crc_control_primary bits
  localparam int CTL_EN    = 7;
  localparam int CTL_GO    = 6;
  localparam int CTL_BUSY  = 5;
  localparam int CTL_ACCUMULATE_MODE  = 4;
  localparam int CTL_SHIFT = 1;
  localparam int CTL_FULL  = 0;
  // scanner_control bits
  localparam int SC_EN     = 7;
  localparam int SC_TRIG   = 6;
  localparam int SC_GO     = 5;
  localparam int SC_REGION = 2;
  localparam int SC_BURST  = 1;
  localparam int SC_BUSY   = 0;
  // Flag register bits
  localparam int FL_CRC    = 0;
  localparam int FL_SCAN   = 1;

  localparam int SCAN_AW = 22;
  localparam logic [7:0]  CTRL_RESET  = 8'h00;
  localparam logic [7:0]  LEN_RESET   = 8'h00;
  localparam logic [15:0] WORD_RESET  = 16'h0000;
  localparam logic [SCAN_AW-1:0] ADR_RESET = '0;

  typedef struct packed {
    logic                 req;     // Read request to the arbiter
    logic                 region;  // 1 EEPROM, 0 program flash
    logic [SCAN_AW-1:0]   addr;    // Word address
  } crcms_memreq_t;

  typedef struct packed {
    logic        grant;   // Request taken this cycle
    logic        valid;   // Read data valid this cycle
    logic [15:0] data;    // Read data
  } crcms_memrsp_t;

endpackage : crcms_pkg

// *** src/crcms_top.sv ***
`timescale 1ns/1ps
// How it works
// (RULE_01) Busy falling from 1 to 0 sets the CRC done flag and raises the interrupt.
// (RULE_02) The CRC done flag clears only by a software write.
// (RULE_03) Data length field holds word length minus one; sets shifts per word.
// (RULE_04) Polynomial length field holds polynomial length minus one; sizes the division.
// (RULE_05) Writing the low data byte starts a word; write high byte first.
// (RULE_06) Full flag is 1 while a word waits, 0 once the shifter took it.
// (RULE_07) Busy reads 1 while shifting is pending, 0 when all bits accumulated.
// (RULE_08) Go bit 1 runs the serial shifter, 0 stops it.
// (RULE_09) Enable bit turns the CRC module on or off.
// (RULE_10) Accumulate mode appends zeros after data; otherwise stop at data end.
// (RULE_11) Shift order 1 shifts LSb first, 0 shifts MSb first.
// (RULE_12) Scanner loads memory words into the data path as needed while go is set.
// (RULE_13) Scanner reads words from low address up through high address.
// (RULE_14) Scan runs while scan go set; ends on clear or address past high.
// (RULE_15) Clearing CRC enable also clears scan go.
// (RULE_16) Scan done flag sets when address passes high; software clears it.
// (RULE_17) Software sets CRC enable and go before scan go.
// (RULE_18) No trigger, no burst: request continuously, arbiter grants by priority; code requests only in SC_REQ, when the CRC can accept data.
// (RULE_19) Trigger on, burst off: request only when the CRC can accept data.
// (RULE_20) Burst on: request always, locking out lower priority until scan ends; code drops the request after each grant and while in SC_WAIT.
// (RULE_21) With trigger and burst, software keeps the trigger source active.
// (RULE_22) Software programs seed, polynomial, lengths and modes before go.
// (RULE_23) Result is final when both flags set and busy and go read 0.
// (RULE_24) Top and bottom polynomial terms are forced to 1; lowest tap bit absent.
// (RULE_25) Augmented mode appends as many zeros as the polynomial length.
// (RULE_26) Data bits above the configured length are ignored.
// (RULE_27) Region bit selects data EEPROM when 1, program flash when 0.
// (RULE_28) Accumulator divides by XOR feedback, one bit per clock while go.
// (RULE_29) Full sets on low byte write, clears on take; busy spans to last bit.
module crcms_top
  import crcms_pkg::*;
(
  input  wire logic          sys_clk,      // 50 MHz clock
  input  wire logic          rst_b,        // Synchronous reset, active low
  input  wire logic          psel,         // APB select
  input  wire logic          penable,      // APB enable
  input  wire logic          pwrite,       // APB direction
  input  wire logic [7:0]    paddr,        // APB byte address
  input  wire logic [31:0]   pwdata,       // APB write data
  output logic      [31:0]   prdata,       // APB read data
  output logic               pready,       // APB ready
  output logic               pslverr,      // APB error, unmapped address
  input  wire logic          scanTrigger,  // Selected trigger source, async
  output crcms_memreq_t      memReq,       // Scanner request to arbiter
  output logic               memLock,      // Burst lock of lower sources
  input  wire crcms_memrsp_t memRsp,       // Arbiter answer
  output logic               crcIrq,       // CRC done interrupt pulse
  output logic               scanIrq       // Scan done interrupt pulse
);

  logic [7:0]  ctrl_q;
  logic [7:0]  len_q;
  logic [7:0]  datH_q;
  logic [7:0]  datL_q;
  logic [15:0] acc_q;
  logic [15:0] xor_q;
  logic [15:0] shift_q;
  logic [7:0]  sctrl_q;
  logic [SCAN_AW-1:0] sLow_q;
  logic [SCAN_AW-1:0] sHigh_q;
  logic        full_q;
  logic [4:0]  bitCnt_q;
  logic [4:0]  zeroCnt_q;
  logic        busy_q;
  logic        crcFlag_q;
  logic        scanFlag_q;
  logic        pend_q;
  logic [2:0]  trigSync_q;
  logic        trig_q;

  logic        apbAcc;
  logic        wrEn;
  logic        mapped;
  logic        takeWord;
  logic        shiftActive;
  logic        zeroActive;
  logic        busyNow;
  logic        goOn;
  logic        crcReady;
  logic        scanWord;
  logic        addrPast;
  logic        scanEnd;

  typedef enum logic [1:0] {SC_IDLE, SC_REQ, SC_WAIT} crcms_scan_t;
  crcms_scan_t scanState_q;

  // Low-order ones covering a field of len+1 bits
  function automatic logic [15:0] crcms_mask(input logic [3:0] len);
    logic [15:0] m;
    m = 16'hFFFF >> (4'd15 - len);
    return m;
  endfunction : crcms_mask

  // One augmented LFSR step: data enters at bit 0, the top bit feeds back; width is poly_length_field+1
  function automatic logic [15:0] crcms_step(input logic [15:0] acc, input logic [15:0] poly,
                                             input logic [3:0] poly_length_field, input logic din);
    logic fb;
    logic [15:0] nxt;
    fb  = acc[poly_length_field];                        // see RULE_04
    nxt = {acc[14:0], din};
    if (fb) begin
      nxt = nxt ^ {poly[15:1], 1'b1};       // see RULE_24
    end
    return nxt & crcms_mask(poly_length_field);
  endfunction : crcms_step

  // Bit selection per order; only bits up to data_length_field count
  function automatic logic crcms_pick(input logic [15:0] sh, input logic [4:0] idx,
                                      input logic lsbFirst);
    logic b;
    b = lsbFirst ? sh[0] : sh[4'(idx - 5'd1)];
    return b;
  endfunction : crcms_pick

  assign apbAcc   = psel && penable;
  assign wrEn     = apbAcc && pwrite;
  assign mapped   = (paddr <= ADDR_FLAGS) && (paddr[1:0] == 2'b00);
  assign goOn     = ctrl_q[CTL_EN] && ctrl_q[CTL_GO];            // see RULE_08
  assign shiftActive = goOn && (bitCnt_q != 5'd0);
  assign zeroActive  = goOn && (bitCnt_q == 5'd0) && (zeroCnt_q != 5'd0);
  assign takeWord = goOn && full_q && !shiftActive && !zeroActive;
  assign busyNow  = full_q || (bitCnt_q != 5'd0) || (zeroCnt_q != 5'd0); // see RULE_07
  assign crcReady = !full_q && !pend_q;
  assign addrPast = sLow_q > sHigh_q;
  assign scanEnd  = sctrl_q[SC_GO] && addrPast && (scanState_q == SC_IDLE);
  assign scanWord = memRsp.valid && (scanState_q == SC_WAIT);

  // APB answers in the access cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          ADDR_CTRL:  prdata <= {24'h00_0000, ctrl_q[7:6], busy_q, ctrl_q[CTL_ACCUMULATE_MODE], 2'b00,
                                 ctrl_q[CTL_SHIFT], full_q};
          ADDR_LEN:   prdata <= {24'h00_0000, len_q};
          ADDR_DATH:  prdata <= {24'h00_0000, datH_q};
          ADDR_DATL:  prdata <= {24'h00_0000, datL_q};
          ADDR_ACC:   prdata <= {16'h0000, acc_q};
          ADDR_XOR:   prdata <= {16'h0000, xor_q[15:1], 1'b1};
          ADDR_SHIFT: prdata <= {16'h0000, shift_q};
          ADDR_SCTRL: prdata <= {24'h00_0000, sctrl_q[7:5], 2'b00, sctrl_q[SC_REGION],
                                 sctrl_q[SC_BURST], scanState_q != SC_IDLE};
          ADDR_SLOW:  prdata <= {10'h000, sLow_q};
          ADDR_SHIGH: prdata <= {10'h000, sHigh_q};
          ADDR_FLAGS: prdata <= {30'h0000_0000, scanFlag_q, crcFlag_q};
          default:    prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Control and configuration registers
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ctrl_q  <= CTRL_RESET;
      len_q   <= LEN_RESET;
      xor_q   <= WORD_RESET;
      sHigh_q <= ADR_RESET;
    end else if (wrEn) begin
      case (paddr)
        ADDR_CTRL:  ctrl_q  <= pwdata[7:0] & 8'hD2;         // see RULE_09
        ADDR_LEN:   len_q   <= pwdata[7:0];                 // see RULE_03
        ADDR_XOR:   xor_q   <= {pwdata[15:1], 1'b0};        // see RULE_24
        ADDR_SHIGH: sHigh_q <= pwdata[SCAN_AW-1:0];
        default:    ;
      endcase
    end
  end

  // Data path holding registers, from software or scanner
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      datH_q <= 8'h00;
      datL_q <= 8'h00;
      full_q <= 1'b0;
    end else begin
      if (takeWord) begin
        full_q <= 1'b0;                                     // see RULE_06
      end
      if (wrEn && paddr == ADDR_DATH) begin
        datH_q <= pwdata[7:0];
      end
      if (wrEn && paddr == ADDR_DATL) begin
        datL_q <= pwdata[7:0];
        full_q <= 1'b1;                                     // see RULE_05 RULE_29
      end
      if (scanWord) begin
        {datH_q, datL_q} <= memRsp.data;                    // see RULE_12
        full_q <= 1'b1;
      end
    end
  end

  // Outstanding memory read, cleared when its word lands
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      pend_q <= 1'b0;
    end else if (scanWord || scanState_q == SC_IDLE) begin
      pend_q <= 1'b0;
    end else if (memReq.req && memRsp.grant) begin
      pend_q <= 1'b1;
    end
  end

  // Shifter and accumulator, one bit per clock
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      shift_q   <= WORD_RESET;
      acc_q     <= WORD_RESET;
      bitCnt_q  <= 5'd0;
      zeroCnt_q <= 5'd0;
    end else begin
      if (wrEn && paddr == ADDR_ACC) begin
        acc_q <= pwdata[15:0];                              // see RULE_22
      end
      if (takeWord) begin
        shift_q  <= {datH_q, datL_q} & crcms_mask(len_q[7:4]); // see RULE_26
        bitCnt_q <= {1'b0, len_q[7:4]} + 5'd1;              // see RULE_03
      end else if (shiftActive) begin
        acc_q    <= crcms_step(acc_q, xor_q, len_q[3:0],
                               crcms_pick(shift_q, bitCnt_q, ctrl_q[CTL_SHIFT])); // see RULE_28
        if (ctrl_q[CTL_SHIFT]) begin
          shift_q <= shift_q >> 1;                          // see RULE_11
        end
        bitCnt_q <= bitCnt_q - 5'd1;
        if (bitCnt_q == 5'd1 && ctrl_q[CTL_ACCUMULATE_MODE] && !full_q) begin
          zeroCnt_q <= {1'b0, len_q[3:0]} + 5'd1;           // see RULE_10 RULE_25
        end
      end else if (zeroActive) begin
        if (full_q) begin
          zeroCnt_q <= 5'd0;
        end else begin
          acc_q     <= crcms_step(acc_q, xor_q, len_q[3:0], 1'b0);
          zeroCnt_q <= zeroCnt_q - 5'd1;
        end
      end
    end
  end

  // Busy edge sets the CRC flag; set wins over a clear
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      busy_q    <= 1'b0;
      crcFlag_q <= 1'b0;
      crcIrq    <= 1'b0;
    end else begin
      busy_q <= busyNow;
      crcIrq <= busy_q && !busyNow;                         // see RULE_01
      if (busy_q && !busyNow) begin
        crcFlag_q <= 1'b1;                                  // see RULE_01
      end else if (wrEn && paddr == ADDR_FLAGS && pwdata[FL_CRC]) begin
        crcFlag_q <= 1'b0;                                  // see RULE_02
      end
    end
  end

  // Trigger input through three stages
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      trigSync_q <= 3'b000;
      trig_q     <= 1'b0;
    end else begin
      trigSync_q <= {trigSync_q[1:0], scanTrigger};
      if (trigSync_q[2] == trigSync_q[1]) begin
        trig_q <= trigSync_q[1];
      end
    end
  end

  // Scanner control, addresses and state
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      sctrl_q     <= CTRL_RESET;
      sLow_q      <= ADR_RESET;
      scanState_q <= SC_IDLE;
    end else begin
      if (wrEn && paddr == ADDR_SCTRL) begin
        sctrl_q <= pwdata[7:0] & 8'hE6;
      end
      if (wrEn && paddr == ADDR_SLOW) begin
        sLow_q <= pwdata[SCAN_AW-1:0];
      end
      if (scanEnd) begin
        sctrl_q[SC_GO] <= 1'b0;                             // see RULE_14
      end
      if (!ctrl_q[CTL_EN] || !ctrl_q[CTL_GO]) begin
        sctrl_q[SC_GO] <= 1'b0;                             // see RULE_15
      end
      case (scanState_q)
        SC_IDLE: begin
          if (sctrl_q[SC_GO] && sctrl_q[SC_EN] && !addrPast && crcReady) begin
            scanState_q <= SC_REQ;
          end
        end
        SC_REQ: begin
          if (!sctrl_q[SC_GO]) begin
            scanState_q <= SC_IDLE;
          end else if (memRsp.grant && memReq.req) begin
            scanState_q <= SC_WAIT;
            sLow_q      <= sLow_q + 1'b1;                   // see RULE_13
          end
        end
        SC_WAIT: begin
          if (memRsp.valid) begin
            scanState_q <= SC_IDLE;
          end
        end
        default: scanState_q <= SC_IDLE;
      endcase
    end
  end

  // Scan end sets the scan done flag; set wins over a clear
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      scanFlag_q <= 1'b0;
      scanIrq    <= 1'b0;
    end else begin
      scanIrq <= scanEnd;                                   // see RULE_16
      if (scanEnd) begin
        scanFlag_q <= 1'b1;                                 // see RULE_16
      end else if (wrEn && paddr == ADDR_FLAGS && pwdata[FL_SCAN]) begin
        scanFlag_q <= 1'b0;
      end
    end
  end

  // Arbiter request per trigger and burst mode
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      memReq <= '0;
    end else begin
      memReq.region <= sctrl_q[SC_REGION];                  // see RULE_27
      memReq.addr   <= (scanState_q == SC_REQ && memRsp.grant) ? sLow_q + 1'b1 :
                       ((scanState_q == SC_IDLE) ? sLow_q : memReq.addr);
      if (sctrl_q[SC_BURST]) begin
        // Drops after each grant and stays low in SC_WAIT until the word lands; a grant that arrives in SC_IDLE brings no word
        memReq.req <= sctrl_q[SC_GO] && scanState_q != SC_WAIT &&
                      !(memReq.req && memRsp.grant);       // see RULE_20
      end else if (sctrl_q[SC_TRIG]) begin
        memReq.req <= scanState_q == SC_REQ && !memRsp.grant && trig_q; // see RULE_19
      end else begin
        memReq.req <= scanState_q == SC_REQ && !memRsp.grant;         // see RULE_18
      end
    end
  end

  // Lower sources stay locked out for the whole burst scan
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      memLock <= 1'b0;
    end else begin
      memLock <= sctrl_q[SC_BURST] && sctrl_q[SC_GO];       // see RULE_20
    end
  end

endmodule : crcms_top

// *** verification/crcms_top_sva.sv ***
`timescale 1ns/1ps
module crcms_top_sva
  import crcms_pkg::*;
(
  input wire logic          sys_clk,     // Clock
  input wire logic          rst_b,       // Reset
  input wire logic          psel,        // APB
  input wire logic          penable,     // APB
  input wire logic          pwrite,      // APB
  input wire logic [7:0]    paddr,       // APB
  input wire logic [31:0]   pwdata,      // APB
  input wire logic [31:0]   prdata,      // APB
  input wire logic          pready,      // APB
  input wire logic          pslverr,     // APB
  input wire logic          scanTrigger, // Trigger
  input wire crcms_memreq_t memReq,      // Request
  input wire logic          memLock,     // Lock
  input wire crcms_memrsp_t memRsp,      // Answer
  input wire logic          crcIrq,      // CRC done
  input wire logic          scanIrq      // Scan done
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  a_rdy_zero_wait: assert property (psel && !penable |=> pready)
    else $error("pready missing in access cycle");
  a_rdy_one_cycle: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_unmapped: assert property (psel && !penable && paddr > ADDR_FLAGS |=> pslverr)
    else $error("unmapped address not refused");
  a_err_zero_data: assert property (pslverr && !pwrite |-> prdata == 32'h0000_0000)
    else $error("refused read returned data");
  a_crc_irq_pulse: assert property (crcIrq |=> !crcIrq)
    else $error("crc interrupt not a pulse");
  a_scan_irq_pulse: assert property (scanIrq |=> !scanIrq)
    else $error("scan interrupt not a pulse");
  a_req_addr_hold: assert property (memReq.req && !memRsp.grant |=> !memReq.req || $stable(memReq.addr))
    else $error("scan address moved while waiting");
  a_req_drop_grant: assert property (memReq.req && memRsp.grant |=> !memReq.req)
    else $error("request held after grant");
  a_reset_quiet: assert property ($rose(rst_b) |-> !crcIrq && !scanIrq && !memReq.req && !memLock)
    else $error("outputs active after reset");

  c_crc_done: cover property (crcIrq);
  c_scan_done: cover property (scanIrq);
  c_burst_lock: cover property (memLock && memRsp.grant);
  c_refused: cover property (pslverr);
endmodule : crcms_top_sva

bind crcms_top crcms_top_sva u_crcms_top_sva (.sys_clk, .rst_b, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .scanTrigger, .memReq, .memLock, .memRsp,
  .crcIrq, .scanIrq);

// *** verification/crcms_mem_model.sv ***
`timescale 1ns/1ps
module crcms_mem_model
  import crcms_pkg::*;
(
  input  wire logic          sys_clk, // Clock
  input  wire logic          rst_b,   // Reset
  input  wire crcms_memreq_t memReq,  // Scanner request
  output crcms_memrsp_t      memRsp   // Grant and data
);
  logic          pendQ;
  logic [2:0]    waitQ;
  crcms_memreq_t reqQ;

  function automatic logic [15:0] word_at(input crcms_memreq_t r);
    return {~r.addr[7:0], r.addr[7:0]} ^ {16{r.region}};
  endfunction : word_at

  always_ff @(posedge sys_clk) begin
    memRsp.grant <= 1'b0;
    memRsp.valid <= 1'b0;
    // Idle data bus never keeps the last word
    memRsp.data  <= ~memRsp.data;
    if (!rst_b) begin
      pendQ       <= 1'b0;
      memRsp.data <= 16'h0000;
    end else if (pendQ) begin
      waitQ <= waitQ - 3'd1;
      if (waitQ == 3'd0) begin
        memRsp.valid <= 1'b1;
        memRsp.data  <= word_at(reqQ);
        pendQ        <= 1'b0;
      end
    end else if (memReq.req && $urandom_range(1) == 0) begin
      memRsp.grant <= 1'b1;
      reqQ         <= memReq;
      waitQ        <= 3'($urandom_range(3));
      pendQ        <= 1'b1;
    end
  end
endmodule : crcms_mem_model

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
module tb_top
  import crcms_pkg::*;
;
  typedef struct packed {logic chk; logic [31:0] d; logic [31:0] m; logic e;} crcms_exp_t;
  logic          sys_clk;
  logic          rst_b;
  logic          psel;
  logic          penable;
  logic          pwrite;
  logic [7:0]    paddr;
  logic [31:0]   pwdata;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  logic          scanTrigger;
  crcms_memreq_t memReq;
  crcms_memrsp_t memRsp;
  logic          memLock;
  logic          crcIrq;
  logic          scanIrq;
  int            miscompares;
  int            nCompared;
  int            nCrc;
  int            nScan;
  crcms_exp_t    expQ[$];
  crcms_exp_t    cur;
  logic [31:0]   rdv;
  logic [15:0]   expAcc;
  logic [7:0]    sc;
  logic [31:0]   ctl;
  logic [15:0]   msgWords [2][2] = '{'{16'h5566, 16'h7788}, '{16'h6655, 16'h8877}};

  crcms_top u_crcms_top (.sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .scanTrigger, .memReq, .memLock, .memRsp, .crcIrq, .scanIrq);
  crcms_mem_model u_crcms_mem_model (.sys_clk, .rst_b, .memReq, .memRsp);

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp32

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic chk, input logic [31:0] m, input logic e);
    int n;
    n = 0;
    expQ.push_back({chk, d, m, e});
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) cmp32(32'(pready), 32'h1);
    rdv = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0, 32'h0, 1'b0);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, e, 1'b1, m, 1'b0);
  endtask : rd

  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    do begin
      apb(1'b0, a, 32'h0, 1'b0, 32'h0, 1'b0);
      n++;
    end while ((rdv & m) !== v && n < 500);
    if ((rdv & m) !== v) cmp32(rdv & m, v);
  endtask : poll

  function automatic logic [15:0] crc_step(input logic [15:0] a, input logic [15:0] w);
    logic fb;
    for (int i = 15; i >= 0; i--) begin
      fb = a[15];
      a  = {a[14:0], w[i]};
      if (fb) a = a ^ 16'h8005;
    end
    return a;
  endfunction : crc_step

  always @(posedge sys_clk) begin
    if (psel && penable && pready === 1'b1 && expQ.size() > 0) begin
      cur = expQ.pop_front();
      if (cur.chk) begin
        cmp32(32'(pslverr), 32'(cur.e));
        if (!pwrite) cmp32(prdata & cur.m, cur.d);
      end
    end
    if (crcIrq === 1'b1) nCrc++;
    if (scanIrq === 1'b1) nScan++;
  end

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", nCompared, miscompares);
    if (miscompares == 0 && nCompared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    #400_000;
    miscompares++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(32'h8600));
    rst_b       = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 8'h00;
    pwdata      = 32'h0;
    scanTrigger = 1'b0;
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(ADDR_CTRL, 32'(CTRL_RESET), 32'hFF);
    rd(ADDR_LEN, 32'(LEN_RESET), 32'hFF);
    apb(1'b0, 8'h40, 32'h0, 1'b1, 32'hFFFF_FFFF, 1'b1);
    apb(1'b1, 8'h02, 32'h0, 1'b1, 32'h0, 1'b1);
    wr(ADDR_LEN, 32'h0000_00FF);
    rd(ADDR_LEN, 32'h0000_00FF, 32'hFF);
    for (int s = 0; s < 2; s++) begin
      ctl = 32'h0000_00D0 | (32'(s) << CTL_SHIFT);
      wr(ADDR_ACC, 32'h0);
      wr(ADDR_XOR, 32'h0000_8004);
      wr(ADDR_CTRL, ctl);
      for (int w = 0; w < 2; w++) begin
        poll(ADDR_CTRL, 32'h1, 32'h0);
        wr(ADDR_DATH, 32'(msgWords[s][w][15:8]));
        wr(ADDR_DATL, 32'(msgWords[s][w][7:0]));
      end
      poll(ADDR_FLAGS, 32'h1, 32'h1);
      rd(ADDR_CTRL, ctl, 32'hFF);
      rd(ADDR_FLAGS, 32'h1, 32'h3);
      rd(ADDR_ACC, s ? 32'h6BA2 : 32'h32D6, 32'hFFFF);
      cmp32(32'(nCrc), 32'(s + 1));
      wr(ADDR_FLAGS, 32'h3);
      rd(ADDR_FLAGS, 32'h0, 32'h3);
    end
    for (int m = 0; m < 3; m++) begin
      expAcc = 16'($urandom());
      sc = 8'hA0 | (m == 1 ? 8'h46 : m == 2 ? 8'h40 : 8'h00);
      ctl = 32'(expAcc);
      for (int a = 0; a < 4; a++) begin
        expAcc = crc_step(expAcc, u_crcms_mem_model.word_at({1'b0, sc[SC_REGION], 22'(m * 16 + 5 + a)}));
      end
      scanTrigger <= (m != 0);
      wr(ADDR_ACC, ctl);
      wr(ADDR_CTRL, 32'h0000_00C0);
      wr(ADDR_SLOW, 32'(m * 16 + 5));
      wr(ADDR_SHIGH, 32'(m * 16 + 8));
      wr(ADDR_SCTRL, 32'(sc));
      @(posedge sys_clk);
      cmp32(32'(memLock), 32'(m == 1));
      poll(ADDR_FLAGS, 32'h3, 32'h3);
      poll(ADDR_CTRL, 32'h20, 32'h0);
      rd(ADDR_ACC, 32'(expAcc), 32'hFFFF);
      rd(ADDR_SCTRL, 32'(sc) & 32'hDF, 32'hFF);
      cmp32(32'(nScan), 32'(m + 1));
      wr(ADDR_FLAGS, 32'h3);
    end
    wr(ADDR_SHIGH, 32'h003F_FFFF);
    wr(ADDR_SCTRL, 32'h0000_00A0);
    wr(ADDR_CTRL, 32'h0);
    rd(ADDR_SCTRL, 32'h80, 32'hFE);
    tally_and_finish();
  end
endmodule : tb_top
